// file: rtl/hfr_pkg.sv
package hfr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int REG_N = 64;
	localparam int FIFO_DEPTH = 16;
	localparam int DISP_N = 13;
	localparam int LEN_W = 16;

	localparam logic [5:0] A_IO_SETUP_ONE = 6'h00;
	localparam logic [5:0] A_IO_SETUP_TWO = 6'h01;
	localparam logic [5:0] A_OPERATION_CONTROL = 6'h02;
	localparam logic [5:0] A_PROTOCOL_MODE_SELECT = 6'h03;
	localparam logic [5:0] A_BIT_RATE_SELECT = 6'h04;
	localparam logic [5:0] A_TYPE_A_SETTINGS = 6'h05;
	localparam logic [5:0] A_TYPE_B_SETTINGS_ONE = 6'h06;
	localparam logic [5:0] A_TYPE_B_AND_F_SETTINGS = 6'h07;
	localparam logic [5:0] A_STREAM_SETUP = 6'h08;
	localparam logic [5:0] A_AUXILIARY_SETUP = 6'h09;
	localparam logic [5:0] A_RECEIVER_SETUP_ONE = 6'h0a;
	localparam logic [5:0] A_RECEIVER_SETUP_TWO = 6'h0b;
	localparam logic [5:0] A_RECEIVER_SETUP_THREE = 6'h0c;
	localparam logic [5:0] A_RECEIVER_SETUP_FOUR = 6'h0d;
	localparam logic [5:0] A_RECEIVE_BLANKING_TIME = 6'h0e;
	localparam logic [5:0] A_REPLY_TIMEOUT_HIGH = 6'h0f;
	localparam logic [5:0] A_REPLY_TIMEOUT_LOW = 6'h10;
	localparam logic [5:0] A_TIMER_CONTROL = 6'h11;
	localparam logic [5:0] A_GENERAL_TIMER_HIGH = 6'h12;
	localparam logic [5:0] A_GENERAL_TIMER_LOW = 6'h13;
	localparam logic [5:0] A_MAIN_INTERRUPT_CONFIG = 6'h14;
	localparam logic [5:0] A_TIMER_NFC_INTERRUPT_CONFIG = 6'h15;
	localparam logic [5:0] A_ERROR_WAKE_INTERRUPT_CONFIG = 6'h16;
	localparam logic [5:0] A_MAIN_INTERRUPT_FLAGS = 6'h17;
	localparam logic [5:0] A_TIMER_NFC_INTERRUPT_FLAGS = 6'h18;
	localparam logic [5:0] A_ERROR_WAKE_INTERRUPT_FLAGS = 6'h19;
	localparam logic [5:0] A_FIFO_STATE_ONE = 6'h1a;
	localparam logic [5:0] A_FIFO_STATE_TWO = 6'h1b;
	localparam logic [5:0] A_COLLISION_POSITION = 6'h1c;
	localparam logic [5:0] A_TX_LENGTH_HIGH = 6'h1d;
	localparam logic [5:0] A_TX_LENGTH_LOW = 6'h1e;
	localparam logic [5:0] A_PEER_RATE_DETECTED = 6'h1f;
	localparam logic [5:0] A_ADC_RESULT = 6'h20;
	localparam logic [5:0] A_ANTENNA_TUNE_CONTROL = 6'h21;
	localparam logic [5:0] A_ANTENNA_TUNE_TARGET = 6'h22;
	localparam logic [5:0] A_ANTENNA_TUNE_RESULT = 6'h23;
	localparam logic [5:0] A_MOD_DEPTH_CONTROL = 6'h24;
	localparam logic [5:0] A_MOD_DEPTH_RESULT = 6'h25;
	localparam logic [5:0] A_DRIVER_MODULATED_LEVEL = 6'h26;
	localparam logic [5:0] A_DRIVER_NORMAL_LEVEL = 6'h27;
	localparam logic [5:0] A_FIELD_DETECT_THRESHOLD = 6'h29;
	localparam logic [5:0] A_REGULATOR_VOLTAGE_CONTROL = 6'h2a;
	localparam logic [5:0] A_REGULATOR_TIMER_STATE = 6'h2b;
	localparam logic [5:0] A_SIGNAL_STRENGTH = 6'h2c;
	localparam logic [5:0] A_GAIN_REDUCTION_STATE = 6'h2d;
	localparam logic [5:0] A_CAP_SENSE_CONTROL = 6'h2e;
	localparam logic [5:0] A_CAP_SENSE_RESULT = 6'h2f;
	localparam logic [5:0] A_AUXILIARY_STATE = 6'h30;

	localparam logic [7:0] IO_SETUP_ONE_RST = 8'h08;
	localparam logic [7:0] CFG_RST = 8'h00;

	localparam int MODE_LSB = 3;
	localparam int MODE_W = 5;
	localparam logic [4:0] MODE_STREAM_SUB = 5'h0e;
	localparam logic [4:0] MODE_STREAM_BPSK = 5'h0f;
	localparam int STX_LSB = 0;
	localparam int STX_W = 3;
	localparam logic [2:0] STX_MAX_SHIFT = 3'h3;
	localparam int AUX_OOK_BIT = 5;

	localparam int SLOT_BASE_FC = 128;
	localparam logic [7:0] SLOT_BASE_CNT = 8'(SLOT_BASE_FC);

	localparam int FS2_EMPTY_BIT = 0;
	localparam int FS2_FULL_BIT = 1;
	localparam int FS2_BUSY_BIT = 2;
	localparam int FS2_CRC_BIT = 3;
endpackage

// file: rtl/hfr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic mclk, // Clock
	input wire logic rst_b, // Async reset, low
	input wire logic in_valid, // Write offer
	input wire logic [WIDTH-1:0] in_data, // Write word
	output logic in_ready, // Not full
	output logic out_valid, // Not empty
	output logic [WIDTH-1:0] out_data, // Head word
	input wire logic out_ready, // Read take
	output logic [$clog2(DEPTH+1)-1:0] count // Words held
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = cnt_r != CW'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	assign count = cnt_r;
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == PW'(DEPTH-1)) ? '0 : PW'(wp_r + 1'b1);
		end
		if (pop) begin
			rp_nxt = (rp_r == PW'(DEPTH-1)) ? '0 : PW'(rp_r + 1'b1);
		end
		if (push && !pop) begin
			cnt_nxt = CW'(cnt_r + 1'b1);
		end else if (pop && !push) begin
			cnt_nxt = CW'(cnt_r - 1'b1);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage carries no reset
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule
`default_nettype wire

// file: rtl/hfr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_regs #(
	parameter int FIFO_DEPTH = hfr_pkg::FIFO_DEPTH
) (
	input wire logic mclk, // 10 MHz system clock
	input wire logic rst_b, // Power-up reset, low
	input wire logic [hfr_pkg::ADDR_W-1:0] reg_addr, // Register address
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [hfr_pkg::DATA_W-1:0] reg_wdata, // Write data
	output logic [hfr_pkg::DATA_W-1:0] reg_rdata, // Read data
	output logic reg_rvalid, // Read data valid
	input wire logic cmd_set_default, // Restore-defaults command
	input wire logic cmd_tx_plain, // Send without CRC
	input wire logic cmd_tx_crc, // Send with CRC
	input wire logic fifo_wr_valid, // FIFO byte offer
	input wire logic [hfr_pkg::DATA_W-1:0] fifo_wr_data, // FIFO byte
	output logic fifo_wr_ready, // FIFO can take byte
	input wire logic [hfr_pkg::DISP_N*hfr_pkg::DATA_W-1:0] disp_vals, // Display sources
	input wire logic fc_tick, // One carrier cycle
	output logic tx_mod_am, // AM modulation on
	output logic tx_mod_ook, // OOK modulation on
	output logic tx_busy, // Stream transmit running
	output logic tx_done, // Transmit finished pulse
	output logic tx_crc_req, // Current send asked for CRC
	output logic stream_selected, // Stream mode chosen
	output logic [hfr_pkg::REG_N*hfr_pkg::DATA_W-1:0] cfg_image // Read-write register contents, zero at all other addresses
);
	import hfr_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH+1);

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_FETCH,
		TX_SLOT
	} hfr_tx_state_t;

	function automatic logic is_rw(input int a);
		case (6'(a))
			A_IO_SETUP_ONE, A_IO_SETUP_TWO, A_OPERATION_CONTROL,
			A_PROTOCOL_MODE_SELECT, A_BIT_RATE_SELECT, A_TYPE_A_SETTINGS,
			A_TYPE_B_SETTINGS_ONE, A_TYPE_B_AND_F_SETTINGS, A_STREAM_SETUP,
			A_AUXILIARY_SETUP, A_RECEIVER_SETUP_ONE, A_RECEIVER_SETUP_TWO,
			A_RECEIVER_SETUP_THREE, A_RECEIVER_SETUP_FOUR, A_RECEIVE_BLANKING_TIME,
			A_REPLY_TIMEOUT_HIGH, A_REPLY_TIMEOUT_LOW, A_TIMER_CONTROL,
			A_GENERAL_TIMER_HIGH, A_GENERAL_TIMER_LOW, A_MAIN_INTERRUPT_CONFIG,
			A_TIMER_NFC_INTERRUPT_CONFIG, A_ERROR_WAKE_INTERRUPT_CONFIG,
			A_TX_LENGTH_HIGH, A_TX_LENGTH_LOW, A_ANTENNA_TUNE_CONTROL,
			A_ANTENNA_TUNE_TARGET, A_MOD_DEPTH_CONTROL, A_DRIVER_MODULATED_LEVEL,
			A_DRIVER_NORMAL_LEVEL, A_FIELD_DETECT_THRESHOLD,
			A_REGULATOR_VOLTAGE_CONTROL, A_CAP_SENSE_CONTROL: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	// Hardware setup registers survive restore-defaults
	function automatic logic is_hw(input int a);
		case (6'(a))
			A_IO_SETUP_ONE, A_IO_SETUP_TWO, A_OPERATION_CONTROL: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	function automatic logic [7:0] cfg_default(input int a);
		if (6'(a) == A_IO_SETUP_ONE) begin
			return IO_SETUP_ONE_RST;
		end
		return CFG_RST;
	endfunction

	// Slot index into disp_vals, -1 when not a display source
	function automatic int disp_index(input logic [5:0] a);
		case (a)
			A_MAIN_INTERRUPT_FLAGS: return 0;
			A_TIMER_NFC_INTERRUPT_FLAGS: return 1;
			A_ERROR_WAKE_INTERRUPT_FLAGS: return 2;
			A_COLLISION_POSITION: return 3;
			A_PEER_RATE_DETECTED: return 4;
			A_ADC_RESULT: return 5;
			A_ANTENNA_TUNE_RESULT: return 6;
			A_MOD_DEPTH_RESULT: return 7;
			A_REGULATOR_TIMER_STATE: return 8;
			A_SIGNAL_STRENGTH: return 9;
			A_GAIN_REDUCTION_STATE: return 10;
			A_CAP_SENSE_RESULT: return 11;
			A_AUXILIARY_STATE: return 12;
			default: return -1;
		endcase
	endfunction

	function automatic logic [7:0] slot_len(input logic [2:0] stx);
		if (stx > STX_MAX_SHIFT) begin
			return SLOT_BASE_CNT;
		end
		return SLOT_BASE_CNT >> stx;
	endfunction

	logic [REG_N-1:0][DATA_W-1:0] cfg_q;

	// Configuration storage, one slot per read-write address
	for (genvar gi = 0; gi < REG_N; gi++) begin : g_reg
		if (is_rw(gi)) begin : g_rw
			logic [DATA_W-1:0] q_r, q_nxt;
			always_comb begin
				q_nxt = q_r;
				if (reg_wr && reg_addr == 6'(gi)) begin
					q_nxt = reg_wdata;
				end
				if (cmd_set_default && !is_hw(gi)) begin
					q_nxt = cfg_default(gi);
				end
			end
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					q_r <= cfg_default(gi);
				end else begin
					q_r <= q_nxt;
				end
			end
			assign cfg_q[gi] = q_r;
		end else begin : g_none
			assign cfg_q[gi] = '0;
		end
	end

	assign cfg_image = cfg_q;

	// FIFO between host writes and the transmitter
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	logic fifo_take;
	logic [CW-1:0] fifo_count;

	hfr_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.in_valid(fifo_wr_valid),
		.in_data(fifo_wr_data),
		.in_ready(fifo_wr_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_take),
		.count(fifo_count)
	);

	// Stream transmit engine
	hfr_tx_state_t st_r, st_nxt;
	logic [DATA_W-1:0] shift_r, shift_nxt;
	logic [2:0] bit_idx_r, bit_idx_nxt;
	logic [7:0] slot_cnt_r, slot_cnt_nxt;
	logic [LEN_W-1:0] bits_left_r, bits_left_nxt;
	logic crc_r, crc_nxt;
	logic done_r, done_nxt;
	logic [MODE_W-1:0] mode_sel;
	logic [STX_W-1:0] stx_sel;
	logic [7:0] cur_len;
	logic [LEN_W-1:0] total_bits;
	logic slot_end;
	logic ook_sel;
	logic mod_bit;

	assign mode_sel = cfg_q[A_PROTOCOL_MODE_SELECT][MODE_LSB +: MODE_W];
	assign stream_selected = (mode_sel == MODE_STREAM_SUB) ||
		(mode_sel == MODE_STREAM_BPSK);
	assign stx_sel = cfg_q[A_STREAM_SETUP][STX_LSB +: STX_W];
	assign cur_len = slot_len(stx_sel);
	assign total_bits = {cfg_q[A_TX_LENGTH_HIGH], cfg_q[A_TX_LENGTH_LOW]};
	assign slot_end = fc_tick && (slot_cnt_r == 8'(cur_len - 1'b1));
	assign ook_sel = cfg_q[A_AUXILIARY_SETUP][AUX_OOK_BIT];

	always_comb begin
		st_nxt = st_r;
		shift_nxt = shift_r;
		bit_idx_nxt = bit_idx_r;
		slot_cnt_nxt = slot_cnt_r;
		bits_left_nxt = bits_left_r;
		crc_nxt = crc_r;
		done_nxt = 1'b0;
		fifo_take = 1'b0;
		case (st_r)
			TX_IDLE: begin
				if ((cmd_tx_plain || cmd_tx_crc) && stream_selected &&
					total_bits != '0) begin
					st_nxt = TX_FETCH;
					bits_left_nxt = total_bits;
					crc_nxt = cmd_tx_crc;
				end
			end
			TX_FETCH: begin
				fifo_take = fifo_out_valid;
				if (fifo_out_valid) begin
					shift_nxt = fifo_out_data;
					bit_idx_nxt = '0;
					slot_cnt_nxt = '0;
					st_nxt = TX_SLOT;
				end
			end
			TX_SLOT: begin
				if (fc_tick) begin
					slot_cnt_nxt = 8'(slot_cnt_r + 1'b1);
				end
				if (slot_end) begin
					slot_cnt_nxt = '0;
					bits_left_nxt = LEN_W'(bits_left_r - 1'b1);
					if (bits_left_r == LEN_W'(1)) begin
						st_nxt = TX_IDLE;
						done_nxt = 1'b1;
					end else if (bit_idx_r == 3'h7) begin
						// Next byte at the boundary; an empty FIFO leaves a gap
						fifo_take = fifo_out_valid;
						if (fifo_out_valid) begin
							shift_nxt = fifo_out_data;
							bit_idx_nxt = '0;
						end else begin
							st_nxt = TX_FETCH;
						end
					end else begin
						shift_nxt = shift_r >> 1;
						bit_idx_nxt = 3'(bit_idx_r + 1'b1);
					end
				end
			end
			default: begin
				st_nxt = TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= TX_IDLE;
			shift_r <= '0;
			bit_idx_r <= '0;
			slot_cnt_r <= '0;
			bits_left_r <= '0;
			crc_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			shift_r <= shift_nxt;
			bit_idx_r <= bit_idx_nxt;
			slot_cnt_r <= slot_cnt_nxt;
			bits_left_r <= bits_left_nxt;
			crc_r <= crc_nxt;
			done_r <= done_nxt;
		end
	end

	assign mod_bit = (st_r == TX_SLOT) && shift_r[0];
	assign tx_mod_am = mod_bit && !ook_sel;
	assign tx_mod_ook = mod_bit && ook_sel;
	assign tx_busy = st_r != TX_IDLE;
	assign tx_done = done_r;
	assign tx_crc_req = crc_r;

	// Register read port
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [DATA_W-1:0] fifo_state_two;

	always_comb begin
		fifo_state_two = '0;
		fifo_state_two[FS2_EMPTY_BIT] = !fifo_out_valid;
		fifo_state_two[FS2_FULL_BIT] = !fifo_wr_ready;
		fifo_state_two[FS2_BUSY_BIT] = tx_busy;
		fifo_state_two[FS2_CRC_BIT] = crc_r;
	end

	always_comb begin
		int idx;
		idx = disp_index(reg_addr);
		rdata_nxt = rdata_r;
		rvalid_nxt = reg_rd;
		if (reg_rd) begin
			if (is_rw(int'(reg_addr))) begin
				rdata_nxt = cfg_q[reg_addr];
			end else if (reg_addr == A_FIFO_STATE_ONE) begin
				rdata_nxt = DATA_W'(fifo_count);
			end else if (reg_addr == A_FIFO_STATE_TWO) begin
				rdata_nxt = fifo_state_two;
			end else if (idx >= 0) begin
				rdata_nxt = disp_vals[idx*DATA_W +: DATA_W];
			end else begin
				rdata_nxt = '0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
endmodule
`default_nettype wire

// file: bench/hfr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_regs_sva #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic mclk, // Clock
	input wire logic rst_b, // Reset, low
	input wire logic [5:0] reg_addr, // Address
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic reg_rvalid, // Read valid
	input wire logic cmd_set_default, // Restore defaults
	input wire logic cmd_tx_plain, // Send plain
	input wire logic cmd_tx_crc, // Send with CRC
	input wire logic [103:0] disp_vals, // Display sources
	input wire logic fc_tick, // Carrier tick
	input wire logic tx_mod_am, // AM on
	input wire logic tx_mod_ook, // OOK on
	input wire logic tx_busy, // Sending
	input wire logic tx_done, // Send end
	input wire logic tx_crc_req, // CRC asked
	input wire logic stream_selected, // Stream mode
	input wire logic [511:0] cfg_image // Register image
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_RD_VALID: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	AST_RD_QUIET: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read valid without read");
	AST_UNMAPPED: assert property (reg_rd && reg_addr inside {6'h28, 6'h3e} |=> reg_rdata == 8'h00)
		else $error("unassigned read not zero");
	AST_DISPLAY: assert property (reg_rd && reg_addr == 6'h17 |=> reg_rdata == $past(disp_vals[7:0]))
		else $error("status read wrong");
	AST_RO_IMAGE: assert property (cfg_image[191:184] == 8'h00)
		else $error("status byte stored");
	AST_WRITE: assert property (reg_wr && reg_addr == 6'h08 && !cmd_set_default |=> cfg_image[71:64] == $past(reg_wdata))
		else $error("write not stored");
	AST_DEFAULT: assert property (cmd_set_default |=> cfg_image[71:64] == 8'h00 && cfg_image[239:232] == 8'h00)
		else $error("defaults not loaded");
	AST_KEEP_HW: assert property (cmd_set_default && !reg_wr |=> $stable(cfg_image[23:0]))
		else $error("hardware setup lost");
	AST_MOD_ONE: assert property (!(tx_mod_am && tx_mod_ook))
		else $error("both modulations on");
	AST_MOD_BUSY: assert property (tx_mod_am || tx_mod_ook |-> tx_busy)
		else $error("modulation while idle");
	AST_START: assert property ($rose(tx_busy) |-> $past(cmd_tx_plain || cmd_tx_crc) && $past(stream_selected))
		else $error("send without command");
	AST_DONE: assert property (tx_done |-> !tx_busy ##1 !tx_done)
		else $error("done pulse wrong");
	AST_SLOT: assert property ($rose(tx_mod_am || tx_mod_ook) && cfg_image[66:64] == 3'h3 && fc_tick |=> (tx_mod_am || tx_mod_ook) [*8])
		else $error("slot cut short");
	AST_CRC: assert property ($rose(tx_busy) && $past(cmd_tx_crc) |-> ##[0:1] tx_crc_req)
		else $error("crc flag missing");
endmodule
bind hfr_regs hfr_regs_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_hfr_regs_sva (.mclk, .rst_b, .reg_addr, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .cmd_set_default, .cmd_tx_plain, .cmd_tx_crc,
	.disp_vals, .fc_tick, .tx_mod_am, .tx_mod_ook, .tx_busy, .tx_done, .tx_crc_req,
	.stream_selected, .cfg_image);
`default_nettype wire

// file: bench/hfr_host.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_host (
	input wire logic mclk, // Clock
	output logic [5:0] reg_addr, // Address
	output logic reg_wr, // Write strobe
	output logic reg_rd, // Read strobe
	output logic [7:0] reg_wdata, // Write data
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic reg_rvalid, // Read valid
	output logic cmd_set_default, // Restore defaults
	output logic cmd_tx_plain, // Send plain
	output logic cmd_tx_crc, // Send with CRC
	output logic fifo_wr_valid, // Byte offer
	output logic [7:0] fifo_wr_data, // Byte
	input wire logic fifo_wr_ready // Room left
);
	initial begin
		{reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
		{cmd_set_default, cmd_tx_plain, cmd_tx_crc, fifo_wr_valid, fifo_wr_data} = '0;
	end
	// Released lines show garbage, not the last value
	task automatic idle();
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
		fifo_wr_data = ~fifo_wr_data;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		idle();
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		ok = reg_rvalid;
		d = reg_rdata;
		idle();
	endtask
	// Order: crc, plain, restore defaults
	task automatic cmd(input logic [2:0] c);
		@(negedge mclk);
		{cmd_tx_crc, cmd_tx_plain, cmd_set_default} = c;
		@(negedge mclk);
		{cmd_tx_crc, cmd_tx_plain, cmd_set_default} = 3'b000;
	endtask
	task automatic push(input logic [7:0] d, output logic ok);
		@(negedge mclk);
		fifo_wr_data = d;
		fifo_wr_valid = 1'b1;
		for (int i = 0; i < 4 && !fifo_wr_ready; i++) @(negedge mclk);
		ok = fifo_wr_ready;
		@(negedge mclk);
		fifo_wr_valid = 1'b0;
		idle();
	endtask
endmodule
`default_nettype wire

// file: bench/hfr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_regs_bench;
	import hfr_pkg::*;
	logic mclk, rst_b, fc_tick, stall, ok;
	logic reg_wr, reg_rd, reg_rvalid, cmd_set_default, cmd_tx_plain, cmd_tx_crc;
	logic fifo_wr_valid, fifo_wr_ready, tx_mod_am, tx_mod_ook, tx_busy, tx_done;
	logic tx_crc_req, stream_selected;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, fifo_wr_data, rv;
	logic [103:0] disp_vals;
	logic [511:0] cfg_image;
	logic [5:0] rw_list [8] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h1d, 6'h1e, 6'h14, 6'h2e};
	int err_total, compares, cyc;
	hfr_regs #(.FIFO_DEPTH(FIFO_DEPTH)) i_hfr_regs (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .reg_rvalid, .cmd_set_default, .cmd_tx_plain, .cmd_tx_crc,
		.fifo_wr_valid, .fifo_wr_data, .fifo_wr_ready, .disp_vals, .fc_tick, .tx_mod_am,
		.tx_mod_ook, .tx_busy, .tx_done, .tx_crc_req, .stream_selected, .cfg_image);
	hfr_host i_hfr_host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
		.cmd_set_default, .cmd_tx_plain, .cmd_tx_crc, .fifo_wr_valid, .fifo_wr_data,
		.fifo_wr_ready);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Stalled carrier ticks half the time
	always @(negedge mclk) begin
		cyc <= cyc + 1;
		fc_tick <= !stall || cyc[2];
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
		i_hfr_host.rd(a, rv, ok);
		check("read valid", 1'b1, ok);
		check("read data", exp, rv);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic test_reset();
		check("image byte 00h", IO_SETUP_ONE_RST, cfg_image[7:0]);
		rdchk(A_IO_SETUP_ONE, IO_SETUP_ONE_RST);
		rdchk(A_STREAM_SETUP, CFG_RST);
		$display("test_reset done");
	endtask
	task automatic test_rw();
		foreach (rw_list[i]) i_hfr_host.wr(rw_list[i], {2'b10, rw_list[i]});
		foreach (rw_list[i]) rdchk(rw_list[i], {2'b10, rw_list[i]});
		i_hfr_host.wr(6'h17, 8'hff);
		i_hfr_host.wr(6'h28, 8'hff);
		i_hfr_host.wr(6'h3e, 8'hff);
		rdchk(6'h17, 8'h3c);
		rdchk(6'h30, 8'hc3);
		rdchk(6'h28, 8'h00);
		rdchk(6'h3e, 8'h00);
		$display("test_rw done");
	endtask
	task automatic test_default();
		i_hfr_host.cmd(3'b001);
		foreach (rw_list[i]) rdchk(rw_list[i], rw_list[i] < 6'h03 ? {2'b10, rw_list[i]} : 8'h00);
		$display("test_default done");
	endtask
	task automatic run_stream(input logic [4:0] mode, input logic [2:0] stx, input logic ook,
		input logic crc, input logic [4:0] len, input logic [15:0] w);
		int slot;
		slot = stx < 3'h4 ? 128 >> stx : 128;
		i_hfr_host.push(w[7:0], ok);
		if (len > 5'd8) i_hfr_host.push(w[15:8], ok);
		i_hfr_host.wr(A_PROTOCOL_MODE_SELECT, {mode, 3'h0});
		i_hfr_host.wr(A_STREAM_SETUP, {5'h00, stx});
		i_hfr_host.wr(A_AUXILIARY_SETUP, {2'b00, ook, 5'h00});
		i_hfr_host.wr(A_TX_LENGTH_HIGH, 8'h00);
		i_hfr_host.wr(A_TX_LENGTH_LOW, {3'h0, len});
		check("stream selected", 1'b1, stream_selected);
		i_hfr_host.cmd({crc, !crc, 1'b0});
		// First slot starts at the next rising edge
		for (int k = 0; k < len; k++) begin
			repeat (slot) begin
				@(negedge mclk);
				check("mod am", w[k] && !ook, tx_mod_am);
				check("mod ook", w[k] && ook, tx_mod_ook);
			end
		end
		@(negedge mclk);
		check("done and idle", 2'b10, {tx_done, tx_busy});
		check("crc flag", crc, tx_crc_req);
		i_hfr_host.rd(A_FIFO_STATE_TWO, rv, ok);
		check("state crc", {crc, 3'b001}, rv[3:0]);
		$display("run_stream done");
	endtask
	task automatic test_not_stream();
		i_hfr_host.wr(A_PROTOCOL_MODE_SELECT, 8'h00);
		i_hfr_host.cmd(3'b010);
		repeat (3) @(negedge mclk);
		check("busy outside stream", 1'b0, tx_busy);
		$display("test_not_stream done");
	endtask
	task automatic test_fill();
		i_hfr_host.wr(A_PROTOCOL_MODE_SELECT, {MODE_STREAM_SUB, 3'h0});
		i_hfr_host.wr(A_STREAM_SETUP, 8'h03);
		i_hfr_host.wr(A_TX_LENGTH_LOW, 8'h80);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			i_hfr_host.push(8'(i), ok);
			check("push taken", 1'b1, ok);
		end
		i_hfr_host.push(8'hee, ok);
		check("push refused", 1'b0, ok);
		rdchk(A_FIFO_STATE_ONE, 8'(FIFO_DEPTH));
		i_hfr_host.rd(A_FIFO_STATE_TWO, rv, ok);
		check("full state", 3'b010, rv[2:0]);
		stall <= 1'b1;
		i_hfr_host.cmd(3'b010);
		for (int i = 0; i < 6000 && tx_done !== 1'b1; i++) @(negedge mclk);
		check("drain done", 1'b1, tx_done);
		stall <= 1'b0;
		i_hfr_host.rd(A_FIFO_STATE_TWO, rv, ok);
		check("empty state", 3'b001, rv[2:0]);
		rdchk(A_FIFO_STATE_ONE, 8'h00);
		$display("test_fill done");
	endtask
	initial begin
		rst_b = 1'b0;
		stall = 1'b0;
		disp_vals = {8'hc3, {12{8'h3c}}};
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		test_reset();
		test_rw();
		test_default();
		run_stream(MODE_STREAM_SUB, 3'h3, 1'b0, 1'b0, 5'd10, 16'h035a);
		run_stream(MODE_STREAM_BPSK, 3'h0, 1'b1, 1'b1, 5'd2, 16'h0002);
		test_not_stream();
		test_fill();
		test_done();
	end
	initial begin
		#3000000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
